// ### dv/rvdc_mem_model.sv
`timescale 1ns/100ps
module rvdc_mem_model(
	input wire logic go_in,
	output logic [1:0] strobe_out,
	output logic [15:0] dq_out
);
	initial {strobe_out, dq_out} = 18'h0;
	// strobe idles low; data flips once released
	always @(posedge go_in) begin
		dq_out = 16'hc35a;
		#60 strobe_out[0] = 1'b1;
		// far group's trace is one core clock longer, so it lands late
		#10 strobe_out[1] = 1'b1;
		#30 strobe_out[0] = 1'b0;
		#10 strobe_out[1] = 1'b0;
		#30 strobe_out[0] = 1'b1;
		#10 strobe_out[1] = 1'b1;
		#30 strobe_out[0] = 1'b0;
		#10 strobe_out[1] = 1'b0;
		#30 dq_out = ~dq_out;
	end
endmodule

// ### dv/rvdc_top_asserts.sv
`timescale 1ns/100ps
`include "rvdc_consts.svh"
module rvdc_top_asserts(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic read_issue_in,
	input wire logic [`RVDC_GROUPS*`RVDC_GRP_W-1:0] read_data_out,
	input wire logic read_data_valid_out,
	input wire logic [`RVDC_GROUPS-1:0] preamble_detect_out
);
	wire [1:0] p = preamble_detect_out;
	wire v = read_data_valid_out;
	wire d = |p;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence beats_s; v [*4] ##1 !v; endsequence
	burst_len_a: assert property ($rose(v) |-> beats_s)
		else $error("length");
	early_valid_a: assert property (read_issue_in |-> !v [*4])
		else $error("early");
	pd_pulse_a: assert property ((p & $past(p)) == '0)
		else $error("width");
	pd_valid_a: assert property (d |-> ##[1:8] v)
		else $error("no valid");
	valid_cause_a: assert property ($rose(v) |->
		$past(d, 2) || $past(d, 3) || $past(d, 4)) else $error("cause");
	pd_quiet_a: assert property (v |-> !d)
		else $error("overlap");
	data_hold_a: assert property (!v ##1 !v |-> $stable(read_data_out))
		else $error("moved");
	reset_quiet_a: assert property ($rose(rst_b_in) |-> !v && !d)
		else $error("reset");
endmodule
bind rvdc_top rvdc_top_asserts u_chk(.*);

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, rst_b = 0, iss = 0, vld;
	logic [5:0] tap = 6'h0;
	logic [1:0] stb, pd;
	logic [15:0] dq, rd;
	int n_errors = 0, compares = 0;
	always #5 clk = ~clk;
	rvdc_top u_dut(.ref_clk_in(clk), .rst_b_in(rst_b), .read_issue_in(iss),
		.read_pulse_tap_in(tap), .strobe_in(stb), .dq_in(dq),
		.read_data_out(rd), .read_data_valid_out(vld),
		.preamble_detect_out(pd));
	rvdc_mem_model u_mem(.go_in(iss), .strobe_out(stb), .dq_out(dq));
	task chk_data(input logic [15:0] g, e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t %h %h", $time, g, e);
		end
	endtask
	task chk_cnt(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t %h %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("errors %0d of %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// fixed window per read; a missing burst shows as a short count
	task burst(input logic [5:0] t, input logic [7:0] e,
		input logic [1:0] ep);
		logic [7:0] n, p0, p1;
		{n, p0, p1} = 24'h0;
		{tap, iss} = {t, 1'b1};
		@(negedge clk) iss = 1'b0;
		repeat (60) begin
			@(negedge clk);
			n = n + {7'h0, vld === 1'b1};
			p0 = p0 + {7'h0, pd[0] === 1'b1};
			p1 = p1 + {7'h0, pd[1] === 1'b1};
			if (vld === 1'b1) chk_data(rd, 16'hc35a);
		end
		chk_cnt(n, e);
		chk_cnt(p0, {7'h0, ep[0]});
		chk_cnt(p1, {7'h0, ep[1]});
	endtask
	// all six codes on both groups, mirrored so they differ per group
	task scen_codes;
		for (int c = 0; c < 6; c++) begin
			burst({3'(5 - c), 3'(c)}, 8'h4, 2'h3);
		end
	endtask
	// undefined codes leave both groups idle, no pulse and no beat
	task scen_refused;
		burst(6'h36, 8'h0, 2'h0);
		burst(6'h3f, 8'h0, 2'h0);
	endtask
	task scen_default;
		burst(6'h00, 8'h4, 2'h3);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		scen_codes;
		scen_refused;
		scen_default;
		close_out;
	end
endmodule

// ### hdl/rvdc_consts.svh
`ifndef RVDC_CONSTS_SVH
`define RVDC_CONSTS_SVH
// Operation
// - after each burst, re-arm valid generation from the returned strobe
// - re-arm only inside the strobe preamble interval; the code arms at the set delay and then takes any later strobe rise
// - each strobe group has its own three-bit delay select field
// - codes 000..101 give 1, 1.5, 2, 2.5, 3, 3.5 clocks; the code arms each half code a full clock after the code below it
// - preamble detect asserts when a proper strobe preamble is seen
// - read data counts as valid only while read valid is high
// - align groups differing by one clock before presenting the word
`define RVDC_GROUPS 2
`define RVDC_GRP_W 8
`define RVDC_SEL_W 3
`define RVDC_BURST_BEATS 4'h4
`define RVDC_SEL_MAX 3'h5
`endif

// ### hdl/rvdc_group.sv
`timescale 1ns/100ps
`include "rvdc_consts.svh"
module rvdc_group
	import rvdc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic read_issue_in,
	input wire logic [`RVDC_SEL_W-1:0] delay_sel_in,
	input wire logic strobe_in,
	input wire logic [`RVDC_GRP_W-1:0] dq_in,
	output logic valid_out,
	output logic [`RVDC_GRP_W-1:0] data_out,
	output logic preamble_detect_out
);
	rvdc_state_t state_r, state_nxt;
	logic [1:0] strobe_sync_r;
	logic strobe_prev_r;
	logic [3:0] cnt_r, cnt_nxt;
	logic [3:0] beats_r, beats_nxt;
	logic half_r;
	logic [`RVDC_GRP_W-1:0] dq_s1_r, dq_s2_r;
	logic strobe_rise;
	logic [3:0] target;
	logic sel_ok;
	logic wait_done;
	assign strobe_rise = strobe_sync_r[1] & ~strobe_prev_r;
	// half-clock codes wait one more full clock then use the opposite edge
	assign target = {2'h0, delay_sel_in[2:1]} + 4'h1;
	assign sel_ok = delay_sel_in <= `RVDC_SEL_MAX;
	// half codes go on the flag raised after the full count has passed
	assign wait_done = delay_sel_in[0] ? half_r : cnt_r == target;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			strobe_sync_r <= 2'h0;
			strobe_prev_r <= 1'b0;
			dq_s1_r <= '0;
			dq_s2_r <= '0;
		end else begin
			strobe_sync_r <= {strobe_sync_r[0], strobe_in};
			strobe_prev_r <= strobe_sync_r[1];
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end
	// opposite edge marks the half-step point of the window
	always_ff @(negedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			half_r <= 1'b0;
		end else begin
			half_r <= (state_r == RVDC_WAIT) & (cnt_r == target + 4'h1);
		end
	end
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		beats_nxt = beats_r;
		case (state_r)
			RVDC_IDLE: begin
				if (read_issue_in && sel_ok) begin
					state_nxt = RVDC_WAIT;
					cnt_nxt = 4'h1;
				end
			end
			RVDC_WAIT: begin
				cnt_nxt = cnt_r + 4'h1;
				if (wait_done) begin
					state_nxt = RVDC_ARM;
				end
			end
			RVDC_ARM: begin
				// window only opens on a strobe rise seen while armed
				if (strobe_rise) begin
					state_nxt = RVDC_BURST;
					beats_nxt = `RVDC_BURST_BEATS;
				end
			end
			RVDC_BURST: begin
				beats_nxt = beats_r - 4'h1;
				if (beats_r == 4'h1) begin
					state_nxt = RVDC_IDLE;
				end
			end
			default: begin
				state_nxt = RVDC_IDLE;
			end
		endcase
	end
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= RVDC_IDLE;
			cnt_r <= 4'h0;
			beats_r <= 4'h0;
			valid_out <= 1'b0;
			data_out <= '0;
			preamble_detect_out <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			beats_r <= beats_nxt;
			valid_out <= state_r == RVDC_BURST;
			data_out <= dq_s2_r;
			preamble_detect_out <= (state_r == RVDC_ARM) & strobe_rise;
		end
	end
endmodule

// ### hdl/rvdc_pkg.sv
package rvdc_pkg;
	typedef enum logic [1:0] {
		RVDC_IDLE,
		RVDC_WAIT,
		RVDC_ARM,
		RVDC_BURST
	} rvdc_state_t;
endpackage

// ### hdl/rvdc_top.sv
`timescale 1ns/100ps
`include "rvdc_consts.svh"
module rvdc_top
	import rvdc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic read_issue_in,
	input wire logic [`RVDC_GROUPS*`RVDC_SEL_W-1:0] read_pulse_tap_in,
	input wire logic [`RVDC_GROUPS-1:0] strobe_in,
	input wire logic [`RVDC_GROUPS*`RVDC_GRP_W-1:0] dq_in,
	output logic [`RVDC_GROUPS*`RVDC_GRP_W-1:0] read_data_out,
	output logic read_data_valid_out,
	output logic [`RVDC_GROUPS-1:0] preamble_detect_out
);
	localparam int G = `RVDC_GROUPS;
	localparam int W = `RVDC_GRP_W;
	logic [G-1:0] gv;
	logic [G-1:0] gpd;
	logic [G*W-1:0] gd;
	logic [G-1:0] gv_d_r;
	logic [G*W-1:0] gd_d_r;
	logic [G-1:0] late_r;
	logic [G-1:0] seen_r;
	logic [G-1:0] lane_v;
	logic [G*W-1:0] lane_d;
	logic all_v;
	genvar i;
	generate
		for (i = 0; i < G; i++) begin : g_grp
			rvdc_group u_grp (
				.ref_clk_in(ref_clk_in),
				.rst_b_in(rst_b_in),
				.read_issue_in(read_issue_in),
				.delay_sel_in(read_pulse_tap_in[i*3 +: 3]),
				.strobe_in(strobe_in[i]),
				.dq_in(dq_in[i*W +: W]),
				.valid_out(gv[i]),
				.data_out(gd[i*W +: W]),
				.preamble_detect_out(gpd[i])
			);
			// early groups are held back one clock to meet late ones
			assign lane_v[i] = late_r[i] ? gv[i] : gv_d_r[i];
			assign lane_d[i*W +: W] = late_r[i] ? gd[i*W +: W]
				: gd_d_r[i*W +: W];
		end
	endgenerate
	assign all_v = &lane_v;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gv_d_r <= '0;
			gd_d_r <= '0;
			late_r <= '0;
			seen_r <= '0;
			read_data_out <= '0;
			read_data_valid_out <= 1'b0;
			preamble_detect_out <= '0;
		end else begin
			gv_d_r <= gv;
			gd_d_r <= gd;
			seen_r <= seen_r | gv;
			// a group whose first beat comes after another's is late
			if (gv != '0 && seen_r == '0) begin
				late_r <= ~gv;
			end
			read_data_valid_out <= all_v;
			read_data_out <= all_v ? lane_d : read_data_out;
			preamble_detect_out <= gpd;
		end
	end
endmodule
